// *** mtrg_pkg.sv ***
package mtrg_pkg;
  localparam int MTRG_ADDR_W = 6;
  // register byte offsets
  localparam logic [5:0] MTRG_OFF_CTRL = 6'h00;
  localparam logic [5:0] MTRG_OFF_MARGIN = 6'h04;
  localparam logic [5:0] MTRG_OFF_FEW3 = 6'h08;
  localparam logic [5:0] MTRG_OFF_SEQ = 6'h0C;
  localparam logic [5:0] MTRG_OFF_PPR = 6'h10;
  localparam logic [5:0] MTRG_OFF_GNUM = 6'h14;
  localparam logic [5:0] MTRG_OFF_GDEN = 6'h18;
  localparam logic [5:0] MTRG_OFF_STAT = 6'h1C;
  localparam logic [5:0] MTRG_OFF_POSLIM = 6'h20;
  localparam logic [5:0] MTRG_OFF_NEGLIM = 6'h24;
  // field positions
  localparam int MTRG_CTRL_ALM_CLR = 0;
  localparam int MTRG_FEW3_FORCE_BIT = 2;
  localparam int MTRG_STAT_ALARM = 0;
  localparam int MTRG_STAT_ACTIVE = 1;
  localparam int MTRG_STAT_OVF = 2;
  localparam int MTRG_STAT_STOP_IMM = 3;
  // values after reset
  localparam logic [31:0] MTRG_MARGIN_RST = 32'h0000000A;
  localparam logic [31:0] MTRG_FEW3_RST = 32'h00000000;
  localparam logic [2:0] MTRG_SEQ_RST = 3'h0;
  localparam logic [31:0] MTRG_PPR_RST = 32'h00800000;
  localparam logic [31:0] MTRG_GNUM_RST = 32'h00000001;
  localparam logic [31:0] MTRG_GDEN_RST = 32'h00000001;
  // margin limits and scale, immediate-stop sequence threshold, pulse limit and response codes
  localparam logic [31:0] MTRG_MARGIN_MAX = 32'h000003E8;
  localparam logic [63:0] MTRG_MARGIN_DIV = 64'h000000000000000A;
  localparam logic [2:0] MTRG_SEQ_IMM_MIN = 3'h4;
  localparam logic [63:0] MTRG_PULSE_MAX = 64'h000000007FFFFFFF;
  localparam logic [1:0] MTRG_RESP_OKAY = 2'h0;
  localparam logic [1:0] MTRG_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {MTRG_POS, MTRG_VEL, MTRG_TRQ} mtrg_mode_e;
  typedef enum {MTRG_IDLE, MTRG_TRACK, MTRG_TRIP} mtrg_state_e;
endpackage

// *** mtrg_guard.sv ***
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module mtrg_guard
  import mtrg_pkg::*;
#(
  parameter int POS_W = 40
)(
  input wire logic clk_sys, // system clock, 25 MHz
  input wire logic reset, // synchronous reset, active high
  input wire logic servo_on, // servo-on state
  input wire logic [1:0] control_mode, // 0 position, 1 velocity, 2 torque
  input wire logic dev_clear, // position deviation being cleared
  input wire logic trial_run, // external trial run
  input wire logic index_search, // index-pulse search
  input wire logic freq_resp, // frequency response measurement
  input wire logic abs_clear, // absolute position clear
  input wire logic overtravel_clear, // deviation clear in overtravel stop
  input wire logic homing, // return to home
  input wire logic cmd_valid, // command increment present
  input wire logic signed [31:0] cmd_delta, // command increment in pulses
  input wire logic signed [POS_W-1:0] motor_pos, // actual motor position, pulses
  output logic range_exceeded_alarm, // alarm level, sticky
  output logic stop_request, // request to alarm stop sequence
  output logic stop_immediate, // immediate stop selected
  input wire logic [MTRG_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [MTRG_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);

  if (POS_W < 34 || POS_W > 62)
  begin
    $error("mtrg_guard: POS_W must be 34..62");
  end

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction

  function automatic logic beyond_31(input logic signed [POS_W-1:0] v);
    logic signed [POS_W-1:0] hi;
    hi = POS_W'(signed'(MTRG_PULSE_MAX));
    return (v > hi) || (v < -hi - POS_W'(1));
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // settings
  logic [31:0] travel_margin_setting;
  logic [31:0] function_expansion_word_three;
  logic [2:0] alarm_stop_sequence;
  logic [31:0] enc_resolution;
  logic [31:0] gear_numerator;
  logic [31:0] gear_denominator;

  logic aw_held;
  logic w_held;
  logic [MTRG_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_ok;
  logic alarm_clr_wr;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  always_comb
  begin
    wr_ok = 1'b1;
    case (aw_addr)
      MTRG_OFF_CTRL, MTRG_OFF_FEW3, MTRG_OFF_SEQ, MTRG_OFF_PPR,
      MTRG_OFF_GNUM, MTRG_OFF_GDEN: wr_ok = 1'b1;
      MTRG_OFF_MARGIN: wr_ok = merge_strb(travel_margin_setting, w_data, w_strb)
                              <= MTRG_MARGIN_MAX;
      default: wr_ok = 1'b0;
    endcase
  end

  assign alarm_clr_wr = wr_fire && wr_ok && aw_addr == MTRG_OFF_CTRL &&
                        w_strb[0] && w_data[MTRG_CTRL_ALM_CLR];

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= MTRG_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? MTRG_RESP_OKAY : MTRG_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      travel_margin_setting <= MTRG_MARGIN_RST;
      function_expansion_word_three <= MTRG_FEW3_RST;
      alarm_stop_sequence <= MTRG_SEQ_RST;
      enc_resolution <= MTRG_PPR_RST;
      gear_numerator <= MTRG_GNUM_RST;
      gear_denominator <= MTRG_GDEN_RST;
    end
    else if (wr_fire && wr_ok)
    begin
      case (aw_addr)
        MTRG_OFF_MARGIN: travel_margin_setting <=
          merge_strb(travel_margin_setting, w_data, w_strb);
        MTRG_OFF_FEW3: function_expansion_word_three <=
          merge_strb(function_expansion_word_three, w_data, w_strb);
        MTRG_OFF_SEQ:
          if (w_strb[0])
            alarm_stop_sequence <= w_data[2:0];
        MTRG_OFF_PPR: enc_resolution <= merge_strb(enc_resolution, w_data, w_strb);
        MTRG_OFF_GNUM: gear_numerator <= merge_strb(gear_numerator, w_data, w_strb);
        MTRG_OFF_GDEN: gear_denominator <= merge_strb(gear_denominator, w_data, w_strb);
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // margin in pulses and its overflow check
  // margin times resolution times gear denominator needs up to 74 bits
  logic [95:0] margin_num;
  logic [95:0] margin_den;
  logic [95:0] margin_pulses;
  logic margin_ovf;

  assign margin_num = 96'(travel_margin_setting) * 96'(enc_resolution) * 96'(gear_denominator);
  assign margin_den = 96'(MTRG_MARGIN_DIV) * 96'(gear_numerator);
  assign margin_pulses = (margin_den == 96'h0) ? 96'h0 : margin_num / margin_den;
  // cross-multiplied so no rounding of a quotient hides the overflow
  assign margin_ovf = (gear_numerator == 32'h0) ||
    (margin_num > 96'(MTRG_PULSE_MAX) * margin_den);

  //////////////////////////////////////////////////////////////////////////
  // tracking
  mtrg_state_e state;
  logic signed [POS_W-1:0] start_pos;
  logic signed [POS_W-1:0] cmd_acc;
  logic signed [POS_W-1:0] ext_max;
  logic signed [POS_W-1:0] ext_min;
  logic signed [POS_W-1:0] next_acc;
  logic signed [POS_W-1:0] pos_lim;
  logic signed [POS_W-1:0] neg_lim;
  logic signed [POS_W-1:0] judged_pos;
  logic signed [POS_W-1:0] margin_s;
  logic suspend;
  logic mode_ok;
  logic pulse_ovf;
  logic over_range;
  logic force_ovf;
  logic trip;

  assign mode_ok = servo_on && control_mode == 2'(MTRG_POS);
  assign suspend = !mode_ok || dev_clear || overtravel_clear || homing ||
                   trial_run || index_search || freq_resp || abs_clear ||
                   travel_margin_setting == 32'h0;
  assign force_ovf = function_expansion_word_three[MTRG_FEW3_FORCE_BIT];
  assign next_acc = cmd_acc + POS_W'(cmd_delta);
  // saturate so an oversized margin cannot wrap the limits
  assign margin_s = (margin_pulses > 96'(MTRG_PULSE_MAX)) ? POS_W'(MTRG_PULSE_MAX) :
                    POS_W'(margin_pulses);
  assign pos_lim = ext_max + margin_s;
  assign neg_lim = ext_min - margin_s;
  assign judged_pos = motor_pos - start_pos;
  assign pulse_ovf = beyond_31(ext_max) || beyond_31(ext_min) || beyond_31(judged_pos) ||
                     beyond_31(pos_lim) || beyond_31(neg_lim) || margin_ovf;
  assign over_range = judged_pos > pos_lim || judged_pos < neg_lim;
  assign trip = state == MTRG_TRACK && !suspend && over_range && (!pulse_ovf || force_ovf);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state <= MTRG_IDLE;
      start_pos <= '0;
      cmd_acc <= '0;
      ext_max <= '0;
      ext_min <= '0;
    end
    else
    begin
      case (state)
        MTRG_IDLE:
          if (!suspend)
          begin
            state <= MTRG_TRACK;
            start_pos <= motor_pos;
            cmd_acc <= '0;
            ext_max <= '0;
            ext_min <= '0;
          end
        MTRG_TRACK:
          if (suspend)
            state <= MTRG_IDLE;
          else if (trip)
            state <= MTRG_TRIP;
          else if (cmd_valid)
          begin
            cmd_acc <= next_acc;
            if (next_acc > ext_max)
              ext_max <= next_acc;
            if (next_acc < ext_min)
              ext_min <= next_acc;
          end
        MTRG_TRIP:
          if (alarm_clr_wr)
            state <= MTRG_IDLE;
        default: state <= MTRG_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // alarm outputs
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      range_exceeded_alarm <= 1'b0;
      stop_request <= 1'b0;
      stop_immediate <= 1'b0;
    end
    else if (trip)
    begin
      range_exceeded_alarm <= 1'b1;
      stop_request <= 1'b1;
      stop_immediate <= alarm_stop_sequence >= MTRG_SEQ_IMM_MIN;
    end
    else if (alarm_clr_wr)
    begin
      range_exceeded_alarm <= 1'b0;
      stop_request <= 1'b0;
      stop_immediate <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read channel
  logic [31:0] rd_mux;

  always_comb
  begin
    rd_mux = 32'h0;
    case (s_axi_araddr)
      MTRG_OFF_CTRL: rd_mux = 32'h0;
      MTRG_OFF_MARGIN: rd_mux = travel_margin_setting;
      MTRG_OFF_FEW3: rd_mux = function_expansion_word_three;
      MTRG_OFF_SEQ: rd_mux = {29'h0, alarm_stop_sequence};
      MTRG_OFF_PPR: rd_mux = enc_resolution;
      MTRG_OFF_GNUM: rd_mux = gear_numerator;
      MTRG_OFF_GDEN: rd_mux = gear_denominator;
      MTRG_OFF_STAT:
      begin
        rd_mux[MTRG_STAT_ALARM] = range_exceeded_alarm;
        rd_mux[MTRG_STAT_ACTIVE] = state == MTRG_TRACK && !suspend;
        rd_mux[MTRG_STAT_OVF] = pulse_ovf;
        rd_mux[MTRG_STAT_STOP_IMM] = stop_immediate;
      end
      MTRG_OFF_POSLIM: rd_mux = pos_lim[31:0];
      MTRG_OFF_NEGLIM: rd_mux = neg_lim[31:0];
      default: rd_mux = 32'h0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= MTRG_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= (s_axi_araddr[1:0] == 2'h0 && s_axi_araddr <= MTRG_OFF_NEGLIM)
                     ? MTRG_RESP_OKAY : MTRG_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// *** mtrg_guard_assertions.sv ***
`timescale 1ns/1ps
module mtrg_guard_assertions
  import mtrg_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic reset, // reset
  input wire logic servo_on, // in
  input wire logic [1:0] control_mode, // in
  input wire logic dev_clear, // in
  input wire logic trial_run, // in
  input wire logic index_search, // in
  input wire logic freq_resp, // in
  input wire logic abs_clear, // in
  input wire logic overtravel_clear, // in
  input wire logic homing, // in
  input wire logic range_exceeded_alarm, // out
  input wire logic stop_request, // out
  input wire logic stop_immediate, // out
  input wire logic s_axi_awvalid, // in
  input wire logic s_axi_awready, // out
  input wire logic s_axi_wvalid, // in
  input wire logic s_axi_wready, // out
  input wire logic s_axi_bvalid, // out
  input wire logic s_axi_arvalid, // in
  input wire logic s_axi_arready, // out
  input wire logic [31:0] s_axi_rdata, // out
  input wire logic s_axi_rvalid, // out
  input wire logic s_axi_rready // in
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  logic susp;
  assign susp = dev_clear | trial_run | index_search | freq_resp | abs_clear
    | overtravel_clear | homing;
  ////////////////////////////////////////////////////////////////////////
  a_alarm_pos_servo: assert property ($rose(range_exceeded_alarm) |->
    $past(servo_on) && $past(control_mode) == 2'h0) else $error("alarm while inactive");
  a_alarm_no_susp: assert property ($rose(range_exceeded_alarm) |->
    !$past(susp)) else $error("alarm while suspended");
  a_stop_mirrors: assert property (stop_request == range_exceeded_alarm)
    else $error("stop request differs from alarm");
  a_imm_needs_alarm: assert property (stop_immediate |-> range_exceeded_alarm)
    else $error("immediate stop without alarm");
  a_alarm_sticky: assert property (range_exceeded_alarm && !s_axi_wvalid
    && !$past(s_axi_wvalid) |=> range_exceeded_alarm) else $error("alarm dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  c_imm: cover property ($rose(stop_immediate));
endmodule
bind mtrg_guard mtrg_guard_assertions u_chk (
  .clk_sys(clk_sys), .reset(reset), .servo_on(servo_on), .control_mode(control_mode),
  .dev_clear(dev_clear), .trial_run(trial_run), .index_search(index_search),
  .freq_resp(freq_resp), .abs_clear(abs_clear), .overtravel_clear(overtravel_clear),
  .homing(homing), .range_exceeded_alarm(range_exceeded_alarm),
  .stop_request(stop_request), .stop_immediate(stop_immediate),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

// *** mtrg_host_model.sv ***
`timescale 1ns/1ps
module mtrg_host_model
  import mtrg_pkg::*;
(
  input wire logic clk_sys, // clock
  output logic cmd_valid, // command present
  output logic signed [31:0] cmd_delta, // increment
  output logic signed [39:0] motor_pos // encoder
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_delta = 32'sh0;
    motor_pos = 40'sh0;
  end
  // stale delta shows its inverse so an unqualified read cannot pass
  task automatic send(input logic signed [31:0] d);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_delta <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_delta <= ~d;
  endtask
  task automatic go(input logic signed [39:0] p);
    @(posedge clk_sys);
    motor_pos <= p;
  endtask
endmodule

// *** mtrg_guard_tb.sv ***
`timescale 1ns/1ps
module mtrg_guard_tb;
  import mtrg_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r; logic a; logic i;} mtrg_exp_s;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic servo_on = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [6:0] susp = 7'h00;
  logic [5:0] awaddr = 6'h00;
  logic [5:0] araddr = 6'h00;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, alarm, stop, imm, cv, ea = 0, ei = 0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, cd;
  logic signed [39:0] mp;
  logic signed [39:0] org = 40'sh00000001F4;
  logic signed [31:0] dl, acc, mx, mn;
  logic [7:0] seed = 8'h55;
  mtrg_exp_s rq[$];
  mtrg_exp_s e;
  logic [1:0] wq[$];
  int error_cnt = 0, n_compared = 0, k;
  localparam logic [1:0] ERR = MTRG_RESP_SLVERR;
  always #20 clk_sys = ~clk_sys;
  mtrg_host_model host (.clk_sys(clk_sys), .cmd_valid(cv), .cmd_delta(cd), .motor_pos(mp));
  mtrg_guard #(.POS_W(40)) uut (.clk_sys(clk_sys), .reset(reset), .servo_on(servo_on),
    .control_mode(mode), .dev_clear(susp[0]), .trial_run(susp[1]), .index_search(susp[2]),
    .freq_resp(susp[3]), .abs_clear(susp[4]), .overtravel_clear(susp[5]),
    .homing(susp[6]), .cmd_valid(cv), .cmd_delta(cd), .motor_pos(mp),
    .range_exceeded_alarm(alarm), .stop_request(stop), .stop_immediate(imm),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
    input logic [1:0] r = MTRG_RESP_OKAY);
    int n;
    logic ha, hw, hb;
    @(posedge clk_sys);
    wq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge clk_sys);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = bvalid;
      @(posedge clk_sys);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) break;
    end
    bready <= 1'b0;
    if (n == 50) error_cnt++;
    if (n == 50) final_report();
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] d,
    input logic [1:0] r = MTRG_RESP_OKAY, input logic [31:0] m = 32'hFFFFFFFF);
    int n;
    logic ha, hr;
    @(posedge clk_sys);
    rq.push_back('{d, m, r, ea, ei});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge clk_sys);
      ha = arvalid & arready;
      hr = rvalid;
      @(posedge clk_sys);
      if (ha) arvalid <= 1'b0;
      if (hr) break;
    end
    rready <= 1'b0;
    if (n == 50) error_cnt++;
    if (n == 50) final_report();
  endtask
  // one boundary on each call: just inside stays quiet, one pulse out trips
  task automatic probe(input logic signed [39:0] ins, input logic signed [39:0] outs,
    input logic [2:0] sq);
    wr(MTRG_OFF_SEQ, {29'h0, sq});
    host.go(org + ins);
    idle(3);
    rd(MTRG_OFF_SEQ, {29'h0, sq});
    host.go(org + outs);
    idle(3);
    ea = 1'b1;
    ei = (sq >= MTRG_SEQ_IMM_MIN);
    rd(MTRG_OFF_STAT, {28'h0, ei, 3'h1}, MTRG_RESP_OKAY, 32'h9);
    host.go(org);
    wr(MTRG_OFF_CTRL, 32'h1);
    ea = 1'b0;
    ei = 1'b0;
    idle(4);
  endtask
  task automatic cond(input int c, input logic v);
    if (c < 7) susp[c] <= v;
    if (c == 7) servo_on <= ~v;
    if (c > 7) mode <= v ? 2'(c - 7) : 2'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(negedge clk_sys)
  begin
    if (bvalid && bready)
      chk("bresp", {30'h0, bresp}, {30'h0, wq.pop_front()});
    if (rvalid && rready)
    begin
      e = rq.pop_front();
      chk("rdata", rdata & e.m, e.d & e.m);
      chk("rresp", {30'h0, rresp}, {30'h0, e.r});
      chk("alarm", {31'h0, alarm}, {31'h0, e.a});
      chk("stop", {31'h0, stop}, {31'h0, e.a});
      chk("imm", {31'h0, imm}, {31'h0, e.i});
    end
  end
  initial
  begin
    idle(2);
    reset <= 1'b0;
    rd(MTRG_OFF_MARGIN, MTRG_MARGIN_RST);
    rd(MTRG_OFF_STAT, 32'h0);
    rd(6'h3C, 32'h0, ERR);
    wr(MTRG_OFF_MARGIN, 32'h3E9, ERR);
    wr(MTRG_OFF_MARGIN, MTRG_MARGIN_MAX);
    rd(MTRG_OFF_MARGIN, MTRG_MARGIN_MAX);
    wr(MTRG_OFF_FEW3, 32'h80000000);
    rd(MTRG_OFF_FEW3, 32'h80000000);
    wr(MTRG_OFF_MARGIN, 32'h0000000A);
    wr(MTRG_OFF_PPR, 32'h00000064);
    host.go(org);
    servo_on <= 1'b1;
    idle(4);
    rd(MTRG_OFF_STAT, 32'h2);
    rd(MTRG_OFF_POSLIM, 32'h00000064);
    rd(MTRG_OFF_NEGLIM, 32'hFFFFFF9C);
    probe(100, 101, 3'h3);
    probe(-100, -101, 3'h4);
    acc = 0;
    mx = 0;
    mn = 0;
    for (k = 0; k < 8; k++)
    begin
      seed = lfsr(seed);
      dl = 32'(seed[5:0]) - 32;
      host.send(dl);
      acc = acc + dl;
      if (acc > mx) mx = acc;
      if (acc < mn) mn = acc;
    end
    idle(2);
    rd(MTRG_OFF_POSLIM, mx + 100);
    rd(MTRG_OFF_NEGLIM, mn - 100);
    probe(mx + 100, mx + 101, 3'h7);
    for (k = 0; k < 8; k++)
    begin
      wr(MTRG_OFF_SEQ, 32'(k));
      rd(MTRG_OFF_SEQ, 32'(k), MTRG_RESP_OKAY, 32'h7);
    end
    for (k = 0; k < 10; k++)
    begin
      cond(k, 1'b1);
      host.send(32'sd1000);
      host.go(org + 40'sd5000);
      idle(3);
      rd(MTRG_OFF_STAT, 32'h0, MTRG_RESP_OKAY, 32'h3);
      host.go(org);
      cond(k, 1'b0);
      idle(3);
    end
    rd(MTRG_OFF_POSLIM, 32'h00000064);
    wr(MTRG_OFF_MARGIN, 32'h0);
    host.go(org + 40'sd5000);
    idle(3);
    rd(MTRG_OFF_STAT, 32'h0, MTRG_RESP_OKAY, 32'h1);
    host.go(org);
    wr(MTRG_OFF_MARGIN, 32'h0000000A);
    wr(MTRG_OFF_PPR, 32'h7FFFFFFF);
    rd(MTRG_OFF_STAT, 32'h2, MTRG_RESP_OKAY, 32'h6);
    wr(MTRG_OFF_MARGIN, 32'h0000000B);
    rd(MTRG_OFF_STAT, 32'h4, MTRG_RESP_OKAY, 32'h4);
    host.go(org + 40'sh4000000000);
    idle(3);
    rd(MTRG_OFF_STAT, 32'h0, MTRG_RESP_OKAY, 32'h1);
    host.go(org);
    wr(MTRG_OFF_FEW3, 32'h00000004);
    host.go(org + 40'sh4000000000);
    idle(3);
    ea = 1'b1;
    ei = 1'b1;
    rd(MTRG_OFF_STAT, 32'h9, MTRG_RESP_OKAY, 32'h9);
    final_report();
  end
endmodule
